// File: flsd_top.sv
// live fault status and diagnostic scan select bank, two-wire port
// assumes an external open-drain pad and asynchronous event sources
//
// Overview of operation
// [R01] status a bits 7,6: channel-1 input over-voltage
// [R02] status a bits 5,4: channel-2 input over-voltage
// [R03] status a bit 3: headset insertion cause
// [R04] status a bit 2: headset removal cause
// [R05] headset button also reported on bit 2
// [R06] bit 1 processing overload; bit 0 reads 0
// [R07] status b bits 7,6: aux monitor thresholds
// [R08] status b bits 5,4: voice activity up/down
// [R09] status b bit 3: mic bias short circuit
// [R10] status b bits 2,1: bias high/low current
// [R11] status b bit 0: mic bias over-voltage
// [R12] scan bit 7 enables channel-1 input scan
// [R13] scan bit 6 enables channel-2 input scan
// [R14] scan bit 5 includes single-ended negative pins
// [R15] scan bit 4 includes ac-coupled channel pins
// [R16] scan bits 3,2: channel-1 output pin scan
// [R17] scan bits 1,0: channel-2 output pin scan
// [R18] live bits track sources; reads/writes don't alter
// [R19] host enables only pins it wants scanned
`timescale 1ns/10ps
`default_nettype none

module flsd_top
#(
	parameter logic [6:0] DEV_ADDR = flsd_pkg::DEV_ADDR_DEFAULT
)
(
	input  wire logic clk_sys_i,                // 50 MHz control clock
	input  wire logic rst_n_i,                  // async reset, low
	// two-wire control port
	input  wire logic scl_i,                    // bus clock pin
	input  wire logic sda_i,                    // bus data pin level
	output logic      sda_o,                    // bus data drive value
	output logic      sda_oe_o,                 // high while pulling low
	// live event sources, asynchronous levels
	input  wire logic ch1_pos_overvolt_i,       // channel-1 positive
	input  wire logic ch1_neg_overvolt_i,       // channel-1 negative
	input  wire logic ch2_pos_overvolt_i,       // channel-2 positive
	input  wire logic ch2_neg_overvolt_i,       // channel-2 negative
	input  wire logic headset_insert_i,         // insertion seen
	input  wire logic headset_remove_i,         // removal seen
	input  wire logic headset_button_i,         // hook press seen
	input  wire logic processing_capacity_ovld_i, // processor overload
	input  wire logic aux_analog_monitor_high_i, // above upper threshold
	input  wire logic aux_analog_monitor_low_i, // below lower threshold
	input  wire logic voice_activity_up_i,      // detector power up
	input  wire logic voice_activity_down_i,    // detector power down
	input  wire logic micbias_short_i,          // bias short circuit
	input  wire logic micbias_high_current_i,   // bias high current
	input  wire logic micbias_low_current_i,    // bias low current
	input  wire logic micbias_overvolt_i,       // bias over-voltage
	// scan selection to the diagnostic scanner
	output logic      input_chan1_scan_enable_o,
	output logic      input_chan2_scan_enable_o,
	output logic      include_single_ended_neg_pin_o,
	output logic      include_ac_coupled_pins_o,
	output logic      out_chan1_pos_scan_enable_o,
	output logic      out_chan1_neg_scan_enable_o,
	output logic      out_chan2_pos_scan_enable_o,
	output logic      out_chan2_neg_scan_enable_o
);

	// reset release chain
	logic [1:0] rst_pipe_q; // release shift register
	logic       rst_n;      // synchronised reset, low

	// bus pins after synchronisation and their events
	logic [1:0] bus_sync;   // {scl, sda}
	logic       scl_rise;   // bus clock rising
	logic       scl_fall;   // bus clock falling
	logic       bus_start;  // start or repeated start
	logic       bus_stop;   // stop

	// live sources
	logic [flsd_pkg::NUM_SRC-1:0] src_async; // raw bundle
	logic [flsd_pkg::NUM_SRC-1:0] src_sync;  // synchronised bundle
	logic [7:0]                   live_a_d;  // next status a
	logic [7:0]                   live_a_q;  // status a
	logic [7:0]                   live_b_d;  // next status b
	logic [7:0]                   live_b_q;  // status b

	// byte engine
	flsd_pkg::flsd_state_e state_q;  // engine state
	logic [2:0]            bit_cnt_q; // bits done in this byte
	logic [7:0]            shift_q;   // byte shift register
	logic                  rx_full_q; // eight bits received
	logic                  addr_ph_q; // byte is the address
	logic                  ptr_ph_q;  // byte is the pointer
	logic                  read_q;    // read transfer
	logic                  sda_oe_q;  // pulling data low
	logic                  sda_o_q;   // drive value, always low
	logic [7:0]            ptr_q;     // register pointer
	logic [7:0]            scan_q;    // scan select register

	// engine decisions
	logic       rx_commit; // received byte is final
	logic       addr_hit;  // address byte names us
	logic       tx_load;   // load next byte to send
	logic       cfg_wr;    // write into scan select
	logic [7:0] rd_data;   // value at the pointer

	// release reset through two flops, assert at once
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rst_pipe_q <= 2'b00;
		else
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
	end

	assign rst_n = rst_pipe_q[1];

	// bus pins pass two flops before anything reads them
	flsd_sync
	#(
		.WIDTH       (2),
		.RESET_VALUE (2'b11)
	)
	u_bus_sync
	(
		.clk_i   (clk_sys_i),
		.rst_n_i (rst_n),
		.async_i ({scl_i, sda_i}),
		.sync_o  (bus_sync)
	);

	// bus clock edges, start and stop
	flsd_edge u_bus_edge
	(
		.clk_i      (clk_sys_i),
		.rst_n_i    (rst_n),
		.scl_i      (bus_sync[1]),
		.sda_i      (bus_sync[0]),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.start_o    (bus_start),
		.stop_o     (bus_stop)
	);

	// gather the event sources into one bundle
	assign src_async = {
		ch1_pos_overvolt_i, ch1_neg_overvolt_i,
		ch2_pos_overvolt_i, ch2_neg_overvolt_i,
		headset_insert_i, headset_remove_i,
		headset_button_i, processing_capacity_ovld_i,
		aux_analog_monitor_high_i, aux_analog_monitor_low_i,
		voice_activity_up_i, voice_activity_down_i,
		micbias_short_i, micbias_high_current_i,
		micbias_low_current_i, micbias_overvolt_i
	};

	// event sources pass two flops as well
	flsd_sync
	#(
		.WIDTH       (flsd_pkg::NUM_SRC),
		.RESET_VALUE ('0)
	)
	u_src_sync
	(
		.clk_i   (clk_sys_i),
		.rst_n_i (rst_n),
		.async_i (src_async),
		.sync_o  (src_sync)
	);

	// arrange status a from the synchronised sources
	always_comb
	begin
		live_a_d = flsd_pkg::LIVE_A_RESET;
		live_a_d[flsd_pkg::LA_CH1_POS_OV] = src_sync[15]; // see [R01]
		live_a_d[flsd_pkg::LA_CH1_NEG_OV] = src_sync[14]; // see [R01]
		live_a_d[flsd_pkg::LA_CH2_POS_OV] = src_sync[13]; // see [R02]
		live_a_d[flsd_pkg::LA_CH2_NEG_OV] = src_sync[12]; // see [R02]
		live_a_d[flsd_pkg::LA_HS_INSERT]  = src_sync[11]; // see [R03]
		live_a_d[flsd_pkg::LA_HS_REMOVE]  = src_sync[10]; // see [R04]
		// removal and button share one position
		live_a_d[flsd_pkg::LA_HS_BUTTON]  = src_sync[10]
			| src_sync[9];                                // see [R05]
		live_a_d[flsd_pkg::LA_PROC_OVLD]  = src_sync[8];  // see [R06]
		live_a_d[flsd_pkg::LA_RESERVED]   = 1'b0;         // see [R06]
	end

	// arrange status b from the synchronised sources
	always_comb
	begin
		live_b_d = flsd_pkg::LIVE_B_RESET;
		live_b_d[flsd_pkg::LB_AUX_HIGH]   = src_sync[7]; // see [R07]
		live_b_d[flsd_pkg::LB_AUX_LOW]    = src_sync[6]; // see [R07]
		live_b_d[flsd_pkg::LB_VAD_UP]     = src_sync[5]; // see [R08]
		live_b_d[flsd_pkg::LB_VAD_DOWN]   = src_sync[4]; // see [R08]
		live_b_d[flsd_pkg::LB_BIAS_SHORT] = src_sync[3]; // see [R09]
		live_b_d[flsd_pkg::LB_BIAS_HI_I]  = src_sync[2]; // see [R10]
		live_b_d[flsd_pkg::LB_BIAS_LO_I]  = src_sync[1]; // see [R10]
		live_b_d[flsd_pkg::LB_BIAS_OV]    = src_sync[0]; // see [R11]
	end

	// live registers follow sources every cycle, no host path in
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			live_a_q <= flsd_pkg::LIVE_A_RESET;
			live_b_q <= flsd_pkg::LIVE_B_RESET;
		end
		else
		begin
			live_a_q <= live_a_d; // see [R18]
			live_b_q <= live_b_d; // see [R18]
		end
	end

	// decisions taken on the bus clock falling edge
	assign rx_commit = (state_q == flsd_pkg::ST_RX) & rx_full_q
		& scl_fall;
	assign addr_hit  = (shift_q[7:1] == DEV_ADDR);
	assign tx_load   = scl_fall & (((state_q == flsd_pkg::ST_RX_ACK)
		& read_q) | (state_q == flsd_pkg::ST_TX_ACK));
	// only the scan register takes data; status writes are dropped
	assign cfg_wr    = rx_commit & ~addr_ph_q & ~ptr_ph_q
		& (ptr_q == flsd_pkg::REG_SCAN);                 // see [R18]
	// reading never changes any status bit
	assign rd_data   = flsd_pkg::flsd_read_reg(ptr_q, live_a_q,
		live_b_q, scan_q);                               // see [R18]

	// byte engine: receive, acknowledge, transmit
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q   <= flsd_pkg::ST_IDLE;
			bit_cnt_q <= 3'h0;
			shift_q   <= 8'h00;
			rx_full_q <= 1'b0;
			addr_ph_q <= 1'b0;
			ptr_ph_q  <= 1'b0;
			read_q    <= 1'b0;
			sda_oe_q  <= 1'b0;
		end
		else if (bus_start)
		begin
			// start restarts with an address byte
			state_q   <= flsd_pkg::ST_RX;
			bit_cnt_q <= 3'h0;
			rx_full_q <= 1'b0;
			addr_ph_q <= 1'b1;
			ptr_ph_q  <= 1'b0;
			read_q    <= 1'b0;
			sda_oe_q  <= 1'b0;
		end
		else if (bus_stop)
		begin
			// stop frees the bus
			state_q  <= flsd_pkg::ST_IDLE;
			sda_oe_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				flsd_pkg::ST_RX:
				begin
					if (scl_rise & ~rx_full_q)
					begin
						// sample data while clock high
						shift_q   <= {shift_q[6:0], bus_sync[0]};
						bit_cnt_q <= bit_cnt_q + 3'h1;
						if (bit_cnt_q == flsd_pkg::LAST_BIT)
							rx_full_q <= 1'b1;
					end
					else if (rx_commit)
					begin
						rx_full_q <= 1'b0;
						bit_cnt_q <= 3'h0;
						if (addr_ph_q & ~addr_hit)
							// not ours, ignore until next start
							state_q <= flsd_pkg::ST_IDLE;
						else
						begin
							// acknowledge the byte
							state_q  <= flsd_pkg::ST_RX_ACK;
							sda_oe_q <= 1'b1;
							if (addr_ph_q)
							begin
								read_q    <= shift_q[0];
								addr_ph_q <= 1'b0;
								ptr_ph_q  <= ~shift_q[0];
							end
							else
								ptr_ph_q <= 1'b0;
						end
					end
				end
				flsd_pkg::ST_RX_ACK:
				begin
					if (tx_load)
					begin
						// first read byte, msb first
						state_q   <= flsd_pkg::ST_TX;
						shift_q   <= rd_data;
						bit_cnt_q <= 3'h0;
						sda_oe_q  <= ~rd_data[7];
					end
					else if (scl_fall)
					begin
						// release and take the next byte
						state_q  <= flsd_pkg::ST_RX;
						sda_oe_q <= 1'b0;
					end
				end
				flsd_pkg::ST_TX:
				begin
					if (scl_fall)
					begin
						if (bit_cnt_q == flsd_pkg::LAST_BIT)
						begin
							// release for the host acknowledge
							state_q  <= flsd_pkg::ST_TX_ACK;
							sda_oe_q <= 1'b0;
						end
						else
						begin
							bit_cnt_q <= bit_cnt_q + 3'h1;
							shift_q   <= {shift_q[6:0], 1'b0};
							sda_oe_q  <= ~shift_q[6];
						end
					end
				end
				flsd_pkg::ST_TX_ACK:
				begin
					if (scl_rise & bus_sync[0])
						// no acknowledge, read ends
						state_q <= flsd_pkg::ST_IDLE;
					else if (tx_load)
					begin
						// acknowledged, send next byte
						state_q   <= flsd_pkg::ST_TX;
						shift_q   <= rd_data;
						bit_cnt_q <= 3'h0;
						sda_oe_q  <= ~rd_data[7];
					end
				end
				default:
				begin
					// idle or unknown code, stay off the bus
					state_q  <= flsd_pkg::ST_IDLE;
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// register pointer: loaded, then steps after each byte
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
			ptr_q <= flsd_pkg::PTR_RESET;
		else if (rx_commit & ptr_ph_q)
			ptr_q <= shift_q;
		else if ((rx_commit & ~addr_ph_q) | tx_load)
			ptr_q <= ptr_q + 8'h01;
	end

	// scan select register, written by the host only
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
			scan_q <= flsd_pkg::SCAN_RESET; // see [R12] [R13]
		else if (cfg_wr)
			scan_q <= shift_q; // see [R14] [R15] [R16] [R17]
	end

	// data drive value is fixed low, open drain
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
			sda_o_q <= 1'b0;
		else
			sda_o_q <= 1'b0;
	end

	// pin outputs
	assign sda_o    = sda_o_q;
	assign sda_oe_o = sda_oe_q;

	// scan selection straight from the register
	assign input_chan1_scan_enable_o =
		scan_q[flsd_pkg::SC_IN_CH1];   // see [R12]
	assign input_chan2_scan_enable_o =
		scan_q[flsd_pkg::SC_IN_CH2];   // see [R13]
	assign include_single_ended_neg_pin_o =
		scan_q[flsd_pkg::SC_SE_NEG];   // see [R14]
	assign include_ac_coupled_pins_o =
		scan_q[flsd_pkg::SC_AC_COUP];  // see [R15]
	assign out_chan1_pos_scan_enable_o =
		scan_q[flsd_pkg::SC_OUT1_POS]; // see [R16]
	assign out_chan1_neg_scan_enable_o =
		scan_q[flsd_pkg::SC_OUT1_NEG]; // see [R16]
	assign out_chan2_pos_scan_enable_o =
		scan_q[flsd_pkg::SC_OUT2_POS]; // see [R17]
	assign out_chan2_neg_scan_enable_o =
		scan_q[flsd_pkg::SC_OUT2_NEG]; // see [R17]

endmodule : flsd_top
`default_nettype wire

// File: flsd_pkg.sv
// constants, state codes and read decode for the live fault status bank
// assumes an 8-bit register pointer and a 7-bit control port address

package flsd_pkg;

	// register offsets on the control port
	localparam logic [7:0] REG_LIVE_A = 8'h42; // live status a
	localparam logic [7:0] REG_LIVE_B = 8'h43; // live status b
	localparam logic [7:0] REG_SCAN   = 8'h46; // scan select

	// values after reset
	localparam logic [7:0] LIVE_A_RESET = 8'h00;
	localparam logic [7:0] LIVE_B_RESET = 8'h00;
	localparam logic [7:0] SCAN_RESET   = 8'h00;
	localparam logic [7:0] UNMAPPED_VAL = 8'h00; // read of a hole
	localparam logic [7:0] PTR_RESET    = 8'h00;

	// control port address, value arbitrary
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2c;

	// live status a field positions
	localparam int unsigned LA_CH1_POS_OV = 7;
	localparam int unsigned LA_CH1_NEG_OV = 6;
	localparam int unsigned LA_CH2_POS_OV = 5;
	localparam int unsigned LA_CH2_NEG_OV = 4;
	localparam int unsigned LA_HS_INSERT  = 3;
	localparam int unsigned LA_HS_REMOVE  = 2;
	localparam int unsigned LA_HS_BUTTON  = 2; // shares the removal bit
	localparam int unsigned LA_PROC_OVLD  = 1;
	localparam int unsigned LA_RESERVED   = 0;

	// live status b field positions
	localparam int unsigned LB_AUX_HIGH   = 7;
	localparam int unsigned LB_AUX_LOW    = 6;
	localparam int unsigned LB_VAD_UP     = 5;
	localparam int unsigned LB_VAD_DOWN   = 4;
	localparam int unsigned LB_BIAS_SHORT = 3;
	localparam int unsigned LB_BIAS_HI_I  = 2;
	localparam int unsigned LB_BIAS_LO_I  = 1;
	localparam int unsigned LB_BIAS_OV    = 0;

	// scan select field positions
	localparam int unsigned SC_IN_CH1   = 7;
	localparam int unsigned SC_IN_CH2   = 6;
	localparam int unsigned SC_SE_NEG   = 5;
	localparam int unsigned SC_AC_COUP  = 4;
	localparam int unsigned SC_OUT1_POS = 3;
	localparam int unsigned SC_OUT1_NEG = 2;
	localparam int unsigned SC_OUT2_POS = 1;
	localparam int unsigned SC_OUT2_NEG = 0;

	// number of live event sources
	localparam int unsigned NUM_SRC = 16;
	localparam logic [2:0]  LAST_BIT = 3'h7; // bit count of a byte end

	// control port byte engine states
	typedef enum logic [2:0]
	{
		ST_IDLE   = 3'b000, // waiting for a start
		ST_RX     = 3'b001, // shifting in a byte
		ST_RX_ACK = 3'b010, // driving our acknowledge
		ST_TX     = 3'b011, // shifting out a byte
		ST_TX_ACK = 3'b100  // sampling the host acknowledge
	} flsd_state_e;

	// register read decode
	function automatic logic [7:0] flsd_read_reg
	(
		input logic [7:0] ptr,
		input logic [7:0] live_a,
		input logic [7:0] live_b,
		input logic [7:0] scan
	);
		logic [7:0] val;
		val = UNMAPPED_VAL;
		case (ptr)
			REG_LIVE_A: val = live_a;
			REG_LIVE_B: val = live_b;
			REG_SCAN:   val = scan;
			default:    val = UNMAPPED_VAL;
		endcase
		return val;
	endfunction : flsd_read_reg

endpackage : flsd_pkg

// File: flsd_sync.sv
// two-flop synchroniser for a bundle of asynchronous levels
// assumes the reset given is already released in the clock domain
`timescale 1ns/10ps
`default_nettype none

module flsd_sync
#(
	parameter int unsigned      WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
	input  wire logic             clk_i,   // local clock
	input  wire logic             rst_n_i, // synchronised reset
	input  wire logic [WIDTH-1:0] async_i, // levels from outside
	output logic      [WIDTH-1:0] sync_o   // safe copies
);

	logic [WIDTH-1:0] meta_q; // first stage, read only by the second
	logic [WIDTH-1:0] sync_q; // second stage

	// two stages, no logic between them
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= RESET_VALUE;
			sync_q <= RESET_VALUE;
		end
		else
		begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule : flsd_sync
`default_nettype wire

// File: flsd_edge.sv
// bus condition detector for the two-wire control port
// assumes clock and data have already been synchronised
`timescale 1ns/10ps
`default_nettype none

module flsd_edge
(
	input  wire logic clk_i,      // local clock
	input  wire logic rst_n_i,    // synchronised reset
	input  wire logic scl_i,      // synchronised bus clock
	input  wire logic sda_i,      // synchronised bus data
	output logic      scl_rise_o, // bus clock rising, one cycle
	output logic      scl_fall_o, // bus clock falling, one cycle
	output logic      start_o,    // data falls while clock high
	output logic      stop_o      // data rises while clock high
);

	logic scl_prev_q; // previous bus clock
	logic sda_prev_q; // previous bus data

	// previous levels, idle bus is high
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end
		else
		begin
			scl_prev_q <= scl_i;
			sda_prev_q <= sda_i;
		end
	end

	// edges and bus conditions
	assign scl_rise_o = scl_i & ~scl_prev_q;
	assign scl_fall_o = ~scl_i & scl_prev_q;
	assign start_o    = scl_i & scl_prev_q & sda_prev_q & ~sda_i;
	assign stop_o     = scl_i & scl_prev_q & ~sda_prev_q & sda_i;

endmodule : flsd_edge
`default_nettype wire

// File: flsd_checker.sv
// checker: port timing of the scan select outputs and the data drive
// assumes it is bound to every instance of flsd_top
`timescale 1ns/10ps
`default_nettype none

module flsd_checker
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic input_chan1_scan_enable_o,
	input wire logic input_chan2_scan_enable_o,
	input wire logic include_single_ended_neg_pin_o,
	input wire logic include_ac_coupled_pins_o,
	input wire logic out_chan1_pos_scan_enable_o,
	input wire logic out_chan1_neg_scan_enable_o,
	input wire logic out_chan2_pos_scan_enable_o,
	input wire logic out_chan2_neg_scan_enable_o
);
	// scan select outputs gathered as one byte, bit 7 first
	wire logic [7:0] scan;
	assign scan = {input_chan1_scan_enable_o, input_chan2_scan_enable_o,
		include_single_ended_neg_pin_o, include_ac_coupled_pins_o,
		out_chan1_pos_scan_enable_o, out_chan1_neg_scan_enable_o,
		out_chan2_pos_scan_enable_o, out_chan2_neg_scan_enable_o};

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	a_scan_reset_zero: assert property ($rose(rst_n_i) |-> scan == 8'h00)
		else $error("scan select not zero after reset");
	a_bus_quiet_boot: assert property ($rose(rst_n_i) |-> !sda_oe_o [*4])
		else $error("data driven right after reset");
	a_drive_value_low: assert property (sda_o == 1'b0)
		else $error("data drive value not low");
	a_scan_with_ack: assert property (!$stable(scan) |-> sda_oe_o)
		else $error("scan changed without an acknowledge");
	a_scan_in_low: assert property (!$stable(scan) |-> !scl_i)
		else $error("scan changed while bus clock high");
	a_oe_steady_high: assert property (scl_i [*6] |-> $stable(sda_oe_o))
		else $error("data drive moved during bus clock high");
	a_oe_rise_low: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("data drive began while bus clock high");
	a_oe_fall_low: assert property ($fell(sda_oe_o) |-> !scl_i)
		else $error("data drive ended while bus clock high");

	// main scenarios reached
	c_scan_write: cover property (!$stable(scan));
	c_drive_seen: cover property ($rose(sda_oe_o));
	c_reset_seen: cover property ($rose(rst_n_i));
endmodule : flsd_checker

bind flsd_top flsd_checker u_chk (.clk_sys_i, .rst_n_i, .scl_i, .sda_o,
	.sda_oe_o, .input_chan1_scan_enable_o, .input_chan2_scan_enable_o,
	.include_single_ended_neg_pin_o, .include_ac_coupled_pins_o,
	.out_chan1_pos_scan_enable_o, .out_chan1_neg_scan_enable_o,
	.out_chan2_pos_scan_enable_o, .out_chan2_neg_scan_enable_o);

`default_nettype wire

// File: flsd_host_model.sv
// host model: two-wire control port master with register tasks
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/10ps
`default_nettype none

module flsd_host_model
(
	input  wire logic clk_i,     // bench clock
	input  wire logic sda_i,     // resolved data wire
	output var logic  scl_o,     // bus clock, idles high
	output var logic  sda_low_o  // high while pulling data low
);
	// bus idle at time zero
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// wait whole clocks, changes land after falling edges
	task automatic wt(input int n);
		repeat (n) @(negedge clk_i);
	endtask : wt

	// start or repeated start, bus clock left low
	task automatic start;
		wt(5);
		sda_low_o = 1'b0;
		wt(5);
		scl_o = 1'b1;
		wt(10);
		sda_low_o = 1'b1;
		wt(10);
		scl_o = 1'b0;
	endtask : start

	// stop, bus left idle
	task automatic stop;
		wt(5);
		sda_low_o = 1'b1;
		wt(5);
		scl_o = 1'b1;
		wt(10);
		sda_low_o = 1'b0;
		wt(10);
	endtask : stop

	// one bit: data moves mid-low, sampled at end of high
	task automatic bit_io(input logic b, output logic r);
		wt(5);
		sda_low_o = !b;
		wt(5);
		scl_o = 1'b1;
		wt(10);
		r = sda_i;
		scl_o = 1'b0;
	endtask : bit_io

	// eight bits msb first, then the ninth bit
	task automatic xfer(input logic [7:0] d, input logic b9,
		output logic [7:0] r, output logic s9);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(b9, s9);
	endtask : xfer

	// register write, ok when all three bytes acknowledged
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       s0, s1, s2;
		start();
		xfer({dev, 1'b0}, 1'b1, r, s0);
		xfer(ptr, 1'b1, r, s1);
		xfer(d, 1'b1, r, s2);
		stop();
		ok = !(s0 | s1 | s2);
	endtask : wr

	// register read, last byte not acknowledged by the host
	task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
		output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       s0, s1, s2, s3;
		start();
		xfer({dev, 1'b0}, 1'b1, r, s0);
		xfer(ptr, 1'b1, r, s1);
		start();
		xfer({dev, 1'b1}, 1'b1, r, s2);
		xfer(8'hff, 1'b1, d, s3);
		stop();
		ok = !(s0 | s1 | s2);
	endtask : rd
endmodule : flsd_host_model

`default_nettype wire

// File: test_fault_live_status_and_diag_scan_cfg.sv
// testbench for the live fault status and scan select bank
// assumes the host model, and the checker bound to the top module
`timescale 1ns/10ps
`default_nettype none

module test_fault_live_status_and_diag_scan_cfg;
	localparam logic [6:0] DEV = flsd_pkg::DEV_ADDR_DEFAULT;
	typedef struct {logic [15:0] src; logic [7:0] a; logic [7:0] b;} flsd_row_s;

	logic            clk_sys_i;   // control clock
	logic            rst_n_i;     // bench reset
	logic [15:0]     src;         // event sources, ch1 pos at bit 15
	logic            ok;          // host saw acknowledges
	logic [7:0]      rd_v;        // value read back
	wire logic       scl;         // bus clock from host
	wire logic       host_low;    // host pulling data low
	wire logic       sda_o;       // device drive value
	wire logic       sda_oe_o;    // device drive enable
	wire logic [7:0] scan;        // scan select outputs
	int              n_mismatch = 0;
	int              comparisons = 0;
	int              cycles = 0;
	// open-drain wire with pull-up
	wire logic sda_w = !(host_low || (sda_oe_o && !sda_o));

	// sources beside the two status bytes they must give
	flsd_row_s rows [11] = '{
		'{16'h0000, 8'h00, 8'h00},
		'{16'h8080, 8'h80, 8'h80},
		'{16'h4040, 8'h40, 8'h40},
		'{16'h2020, 8'h20, 8'h20},
		'{16'h1010, 8'h10, 8'h10},
		'{16'h0808, 8'h08, 8'h08},
		'{16'h0404, 8'h04, 8'h04},
		'{16'h0202, 8'h04, 8'h02},
		'{16'h0101, 8'h02, 8'h01},
		'{16'h0600, 8'h04, 8'h00},
		'{16'hffff, 8'hfe, 8'hff}
	};

	flsd_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.ch1_pos_overvolt_i(src[15]), .ch1_neg_overvolt_i(src[14]),
		.ch2_pos_overvolt_i(src[13]), .ch2_neg_overvolt_i(src[12]),
		.headset_insert_i(src[11]), .headset_remove_i(src[10]),
		.headset_button_i(src[9]), .processing_capacity_ovld_i(src[8]),
		.aux_analog_monitor_high_i(src[7]),
		.aux_analog_monitor_low_i(src[6]), .voice_activity_up_i(src[5]),
		.voice_activity_down_i(src[4]), .micbias_short_i(src[3]),
		.micbias_high_current_i(src[2]), .micbias_low_current_i(src[1]),
		.micbias_overvolt_i(src[0]),
		.input_chan1_scan_enable_o(scan[7]),
		.input_chan2_scan_enable_o(scan[6]),
		.include_single_ended_neg_pin_o(scan[5]),
		.include_ac_coupled_pins_o(scan[4]),
		.out_chan1_pos_scan_enable_o(scan[3]),
		.out_chan1_neg_scan_enable_o(scan[2]),
		.out_chan2_pos_scan_enable_o(scan[1]),
		.out_chan2_neg_scan_enable_o(scan[0]));

	flsd_host_model host (.clk_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl),
		.sda_low_o(host_low));

	// 50 MHz clock
	initial
	begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	// counts, verdict and end of run
	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// compare one byte, report a mismatch at once
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// hang guard, run needs about 26600 cycles
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	initial
	begin
		rst_n_i = 1'b0;
		src = 16'h0000;
		repeat (2) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		chk("scan pins reset", 8'h00, scan);
		host.rd(DEV, flsd_pkg::REG_SCAN, rd_v, ok);
		chk("scan reset", 8'h00, rd_v);
		// table of live source patterns
		foreach (rows[i])
		begin
			src = rows[i].src;
			repeat (5) @(negedge clk_sys_i);
			host.rd(DEV, flsd_pkg::REG_LIVE_A, rd_v, ok);
			chk("live a", rows[i].a, rd_v);
			host.rd(DEV, flsd_pkg::REG_LIVE_B, rd_v, ok);
			chk("live b", rows[i].b, rd_v);
		end
		// scan select, two complementary patterns
		host.wr(DEV, flsd_pkg::REG_SCAN, 8'ha5, ok);
		chk("scan a5 pins", 8'ha5, scan);
		host.rd(DEV, flsd_pkg::REG_SCAN, rd_v, ok);
		chk("scan a5 read", 8'ha5, rd_v);
		host.wr(DEV, flsd_pkg::REG_SCAN, 8'h5a, ok);
		chk("scan 5a pins", 8'h5a, scan);
		host.rd(DEV, flsd_pkg::REG_SCAN, rd_v, ok);
		chk("scan 5a read", 8'h5a, rd_v);
		// write to status dropped, repeated reads do not clear
		src = 16'h8001;
		host.wr(DEV, flsd_pkg::REG_LIVE_A, 8'h00, ok);
		chk("status write ack", 8'h01, {7'h00, ok});
		host.rd(DEV, flsd_pkg::REG_LIVE_A, rd_v, ok);
		chk("status first read", 8'h80, rd_v);
		host.rd(DEV, flsd_pkg::REG_LIVE_A, rd_v, ok);
		chk("status second read", 8'h80, rd_v);
		// unmapped place reads zero, scan untouched
		host.wr(DEV, 8'h50, 8'hff, ok);
		host.rd(DEV, 8'h50, rd_v, ok);
		chk("unmapped read", 8'h00, rd_v);
		chk("scan after hole", 8'h5a, scan);
		// foreign address refused
		host.wr(DEV ^ 7'h01, flsd_pkg::REG_SCAN, 8'h00, ok);
		chk("foreign ack", 8'h00, {7'h00, ok});
		chk("scan after foreign", 8'h5a, scan);
		// reset in mid run clears the scan select
		rst_n_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		chk("scan mid reset", 8'h00, scan);
		rst_n_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		// port answers again after the second release
		host.rd(DEV, flsd_pkg::REG_SCAN, rd_v, ok);
		chk("scan read after reset", 8'h00, rd_v);
		chk("ack after reset", 8'h01, {7'h00, ok});
		end_sim();
	end
endmodule : test_fault_live_status_and_diag_scan_cfg

`default_nettype wire
